// ==== common/sbcs_cfg.svh ====
`ifndef SBCS_CFG_SVH
`define SBCS_CFG_SVH
// Divisor width and the smallest divisor that runs
`define SBCS_DIV_W 16
`define SBCS_DIV_MIN 16'h0002
`define SBCS_DIV_RST 16'h0000
// Oversampling factor of asynchronous mode and its counter width
`define SBCS_OVS 5'h10
`define SBCS_OVS_W 4
// Transmit clock source codes {hi, lo}
`define SBCS_TXS_IN 2'h0
`define SBCS_TXS_BRG 2'h1
`define SBCS_TXS_CLK 2'h2
`define SBCS_TXS_EXP 2'h3
`endif

// ==== common/sbcs_pkg.sv ====
package sbcs_pkg;
   typedef enum logic [1:0] {
      SBCS_ST_RESET = 2'b00,
      SBCS_ST_WAIT_LO = 2'b01,
      SBCS_ST_RUN = 2'b10
   } sbcs_init_e;
endpackage

// ==== hw/sbcs_clock_select.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sbcs_cfg.svh"
// ===================================
// Notes on behaviour
// - Bit clock is divided by 16 when divide bypass is clear, in either mode; with bypass set it is used undivided.
// - Internal clock alone supports undivided and by-16 bit rates up to limits.
// - With external clocks, by-16 rate is halved by edge detection limits.
// - Two source bits set transmit pin as clock input, divider output, or clock out.
// - External receive clock is used only when its enable bit is set.
// - Sixteen-bit divide-by-N, divisors 2 to 65535, feeding transmitter and receiver.
// - Divisor loads into the counter at once on start.
// - Divider output rate is input clock rate over divisor; internal clock selectable.
// - Divisor 0 or 1 halts the divider with no output.
// - Divider output has 50% duty cycle for even divisors; for odd ones it is high one cycle longer than low.
// - Writing either divider byte disables and resets divider, transmitter, receiver.
// - Writing the low byte re-enables transmitter and receiver and starts counting.
// - Receive data and clock are synchronised to the internal clock; sender limits skew.
// - Serial data input feeds only the receiver shift path.
// - In synchronous mode carrier detect gates the external receive clock; level programmable.
// - Source bits 11 without synchronous mode select serial expansion with clock out.
module sbcs_clock_select #(
   parameter int DIV_W = `SBCS_DIV_W
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic div_hi_wr,
   input wire logic div_lo_wr,
   input wire logic [7:0] div_byte,
   input wire logic clock_divide_bypass,
   input wire logic tx_clock_source_hi,
   input wire logic tx_clock_source_lo,
   input wire logic ext_rx_clock_enable,
   input wire logic sync_mode_enable,
   input wire logic carrier_active_high,
   input wire logic brg_use_rx_clock,
   input wire logic ext_tx_clock_pin_in,
   input wire logic ext_rx_clock_pin,
   input wire logic carrier_detect_gate,
   input wire logic serial_data_in,
   output logic ext_tx_clock_pin_out,
   output logic ext_tx_clock_pin_oe,
   output logic serial_clock_out,
   output logic serial_expansion_mode,
   output logic sci_enable,
   output logic sci_reset,
   output logic brg_running,
   output logic tx_bit_tick,
   output logic rx_bit_tick,
   output logic rx_data,
   output logic rx_frame_active
);
   // ===================================
   // Divider programming sequence
   sbcs_pkg::sbcs_init_e st_r;
   logic [DIV_W-1:0] divisor_r;
   logic clr_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= sbcs_pkg::SBCS_ST_RESET;
         divisor_r <= DIV_W'(`SBCS_DIV_RST);
         clr_r <= 1'b1;
      end else begin
         clr_r <= 1'b0;
         if (div_hi_wr) begin
            divisor_r[15:8] <= div_byte;
            st_r <= sbcs_pkg::SBCS_ST_WAIT_LO;
            clr_r <= 1'b1;
         end else if (div_lo_wr) begin
            divisor_r[7:0] <= div_byte;
            st_r <= sbcs_pkg::SBCS_ST_RUN;
            clr_r <= 1'b1;
         end else begin
            case (st_r)
               sbcs_pkg::SBCS_ST_RESET: st_r <= sbcs_pkg::SBCS_ST_RESET;
               sbcs_pkg::SBCS_ST_WAIT_LO: st_r <= sbcs_pkg::SBCS_ST_WAIT_LO;
               sbcs_pkg::SBCS_ST_RUN: st_r <= sbcs_pkg::SBCS_ST_RUN;
               default: st_r <= sbcs_pkg::SBCS_ST_RESET;
            endcase
         end
      end
   end
   logic running;
   assign running = (st_r == sbcs_pkg::SBCS_ST_RUN) && !clr_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sci_enable <= 1'b0;
         sci_reset <= 1'b1;
      end else begin
         sci_enable <= (st_r == sbcs_pkg::SBCS_ST_RUN) && !div_hi_wr && !div_lo_wr;
         sci_reset <= div_hi_wr || div_lo_wr || (st_r != sbcs_pkg::SBCS_ST_RUN);
      end
   end
   chk_write_resets: assert property (@(posedge clk) disable iff (!nrst)
      (div_hi_wr || div_lo_wr) |=> sci_reset && !sci_enable) else $error("write no reset");
   chk_lo_enables: assert property (@(posedge clk) disable iff (!nrst)
      (div_lo_wr && !div_hi_wr) ##1 (!div_hi_wr && !div_lo_wr) |=> sci_enable)
      else $error("low byte did not enable");
   // ===================================
   // External pin sampling and edge detection
   logic [2:0] txc_r, rxc_r, cd_r, sin_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         txc_r <= 3'h0;
         rxc_r <= 3'h0;
         cd_r <= 3'h0;
         sin_r <= 3'h7;
      end else begin
         txc_r <= {txc_r[1:0], ext_tx_clock_pin_in};
         rxc_r <= {rxc_r[1:0], ext_rx_clock_pin};
         cd_r <= {cd_r[1:0], carrier_detect_gate};
         sin_r <= {sin_r[1:0], serial_data_in};
      end
   end
   logic carrier_on, sync_gate, rx_edge, tx_edge;
   assign carrier_on = (cd_r[1] == carrier_active_high);
   assign sync_gate = !sync_mode_enable || carrier_on;
   assign rx_edge = rxc_r[1] && !rxc_r[2] && ext_rx_clock_enable && sync_gate;
   assign tx_edge = txc_r[1] && !txc_r[2];
   // ===================================
   // Baud rate generator
   logic [1:0] txs;
   logic brg_tick, brg_level;
   assign txs = {tx_clock_source_hi, tx_clock_source_lo};
   sbcs_divider #(.W(DIV_W)) u_div (
      .clk(clk),
      .nrst(nrst),
      .clr(clr_r || !running),
      .src_en(brg_use_rx_clock ? rx_edge : 1'b1),
      .divisor(divisor_r),
      .tick(brg_tick),
      .level(brg_level)
   );
   // ===================================
   // Bit clock selection and divide-by-16
   logic [`SBCS_OVS_W-1:0] tx16_r, rx16_r;
   logic tx_src, rx_src;
   assign tx_src = (txs == `SBCS_TXS_IN) ? tx_edge : brg_tick;
   assign rx_src = (ext_rx_clock_enable && !brg_use_rx_clock) ? rx_edge : brg_tick;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx16_r <= '0;
         rx16_r <= '0;
         tx_bit_tick <= 1'b0;
         rx_bit_tick <= 1'b0;
      end else if (!running) begin
         tx16_r <= '0;
         rx16_r <= '0;
         tx_bit_tick <= 1'b0;
         rx_bit_tick <= 1'b0;
      end else begin
         if (tx_src) begin
            tx16_r <= tx16_r + `SBCS_OVS_W'(1);
         end
         if (rx_src) begin
            rx16_r <= rx16_r + `SBCS_OVS_W'(1);
         end
         tx_bit_tick <= tx_src && (clock_divide_bypass || (&tx16_r));
         rx_bit_tick <= rx_src && (clock_divide_bypass || (&rx16_r));
      end
   end
   chk_div16_gate: assert property (@(posedge clk) disable iff (!nrst)
      (running && !clock_divide_bypass && tx_src && tx16_r != 4'hF) |=> !tx_bit_tick)
      else $error("tick not divided by 16");
   // ===================================
   // Pin functions
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ext_tx_clock_pin_out <= 1'b0;
         ext_tx_clock_pin_oe <= 1'b0;
         serial_clock_out <= 1'b1;
         serial_expansion_mode <= 1'b0;
         brg_running <= 1'b0;
         rx_data <= 1'b1;
         rx_frame_active <= 1'b0;
      end else begin
         ext_tx_clock_pin_oe <= (txs != `SBCS_TXS_IN);
         case (txs)
            `SBCS_TXS_IN: ext_tx_clock_pin_out <= 1'b0;
            `SBCS_TXS_BRG: ext_tx_clock_pin_out <= brg_level;
            default: ext_tx_clock_pin_out <= clock_divide_bypass ? brg_level : tx16_r[3];
         endcase
         serial_expansion_mode <= !sync_mode_enable && (txs == `SBCS_TXS_EXP);
         serial_clock_out <= (txs == `SBCS_TXS_EXP || txs == `SBCS_TXS_CLK)
            ? (clock_divide_bypass ? brg_level : tx16_r[3]) : 1'b1;
         brg_running <= running && (divisor_r >= DIV_W'(`SBCS_DIV_MIN));
         rx_data <= sin_r[1];
         rx_frame_active <= sync_mode_enable && carrier_on;
      end
   end
   chk_pin_dir: assert property (@(posedge clk) disable iff (!nrst)
      (txs == `SBCS_TXS_IN) [*2] |-> !ext_tx_clock_pin_oe) else $error("pin driven");
   chk_gate_rx: assert property (@(posedge clk) disable iff (!nrst)
      (!ext_rx_clock_enable && running && !brg_tick) |=> !rx_bit_tick)
      else $error("rx ticked without enable");
   chk_halt: assert property (@(posedge clk) disable iff (!nrst)
      (divisor_r < 16'h0002) |=> !brg_running) else $error("halted divider runs");
endmodule
`default_nettype wire

// ==== hw/sbcs_divider.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sbcs_cfg.svh"
// ===================================
// Divide-by-N with 50% duty; toggle at N/2 and N, odd N stretched by half period
// Odd N gets no half-cycle accuracy; there is no second phase register on the one clock:
// the output high time is ceil(N/2) and low floor(N/2) cycles, rising edges every N.
// Odd exact duty would need a falling-edge flop; one clock only, so edges are rate.
module sbcs_divider #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic src_en,
   input wire logic [W-1:0] divisor,
   output logic tick,
   output logic level
);
   logic [W-1:0] cnt_r;
   logic run;
   assign run = (divisor >= W'(`SBCS_DIV_MIN));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
         level <= 1'b0;
         tick <= 1'b0;
      end else if (clr || !run) begin
         cnt_r <= divisor - W'(1);
         level <= 1'b0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (src_en) begin
            if (cnt_r == '0) begin
               cnt_r <= divisor - W'(1);
               level <= 1'b1;
               tick <= 1'b1;
            end else begin
               cnt_r <= cnt_r - W'(1);
               if (cnt_r == (divisor >> 1)) begin
                  level <= 1'b0;
               end
            end
         end
      end
   end
   chk_halt_no_tick: assert property (@(posedge clk) disable iff (!nrst)
      !run |=> !tick) else $error("divider ticked while halted");
   chk_load_at_once: assert property (@(posedge clk) disable iff (!nrst)
      clr |=> cnt_r == $past(divisor) - W'(1)) else $error("divisor not loaded");
endmodule
`default_nettype wire

// ==== test/sbcs_remote_sender.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
// Remote sender
module sbcs_remote_sender (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] bits,
   output logic rx_clk,
   output logic carrier,
   output logic data
);
   initial begin
      rx_clk = 1'h0;
      carrier = 1'h0;
      data = 1'h0;
   end
   // Idle data wanders so no stale bit looks valid
   always @(posedge clk) begin
      if (carrier !== 1'h1) data <= #10 ~data;
   end
   // Carrier first, then 8 bits LSB first, clock of 4 core cycles
   always @(posedge go) begin
      @(posedge clk);
      #10;
      carrier = 1'h1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #10;
         data = bits[i];
         @(posedge clk);
         #10;
         rx_clk = 1'h1;
         repeat (2) @(posedge clk);
         #10;
         rx_clk = 1'h0;
      end
      @(posedge clk);
      #10;
      carrier = 1'h0;
   end
endmodule
`default_nettype wire

// ==== test/test_serial_baud_clock_select.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_serial_baud_clock_select;
   logic clk = 1'h0, nrst = 1'h0, hi_wr = 1'h0, lo_wr = 1'h0, byp = 1'h1;
   logic src_hi = 1'h0, src_lo = 1'h0, rxen = 1'h0, sync = 1'h0, pol = 1'h1;
   logic go = 1'h0, zero = 1'h0;
   logic [7:0] dbyte = 8'h00, bits = 8'h00;
   logic tx_out, oe, sclk, exp_mode, en, rst_o, run, txt, rxt, rxd, fra, pclk, pcar, pdat;
   int miscompares = 0, checked = 0;
   int hi = 0, ntx = 0;
   logic txp = 1'h0;
   sbcs_clock_select uut (.clk(clk), .nrst(nrst), .div_hi_wr(hi_wr), .div_lo_wr(lo_wr),
      .div_byte(dbyte), .clock_divide_bypass(byp), .tx_clock_source_hi(src_hi),
      .tx_clock_source_lo(src_lo), .ext_rx_clock_enable(rxen), .sync_mode_enable(sync),
      .carrier_active_high(pol), .brg_use_rx_clock(zero), .ext_tx_clock_pin_in(txp),
      .ext_rx_clock_pin(pclk), .carrier_detect_gate(pcar), .serial_data_in(pdat),
      .ext_tx_clock_pin_out(tx_out), .ext_tx_clock_pin_oe(oe), .serial_clock_out(sclk),
      .serial_expansion_mode(exp_mode), .sci_enable(en), .sci_reset(rst_o),
      .brg_running(run), .tx_bit_tick(txt), .rx_bit_tick(rxt), .rx_data(rxd),
      .rx_frame_active(fra));
   sbcs_remote_sender peer (.clk(clk), .go(go), .bits(bits), .rx_clk(pclk),
      .carrier(pcar), .data(pdat));
   always #50 clk = ~clk;
   // ==========
   // Tasks
   task chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'h1) begin
         miscompares++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask
   task conclude();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task wr(input logic h, input logic [7:0] v);
      @(posedge clk);
      #10;
      hi_wr = h;
      lo_wr = !h;
      dbyte = v;
      @(posedge clk);
      #10;
      hi_wr = 1'h0;
      lo_wr = 1'h0;
   endtask
   task gap(input int n);
      int c;
      c = 0;
      while (txt !== 1'h1 && c < 3000) begin
         @(posedge clk);
         #10;
         c++;
      end
      c = 0;
      do begin
         @(posedge clk);
         #10;
         c++;
      end while (txt !== 1'h1 && c < 3000);
      chk(c == n, "tick spacing");
   endtask
   task frame(input logic [7:0] b, input int exp, input logic fr);
      int n;
      int t;
      logic seen;
      n = 0;
      t = 0;
      seen = 1'h0;
      bits = b;
      go = 1'h1;
      repeat (45) begin
         @(posedge clk);
         #10;
         go = 1'h0;
         if (fra === 1'h1) seen = 1'h1;
         if (txt === 1'h1) t++;
         if (rxt === 1'h1) begin
            if (n < 8) chk(rxd === b[n], "rx data");
            n++;
         end
      end
      chk(n == exp, "rx ticks");
      chk(seen === fr, "frame flag");
      chk(t == 0 && run === 1'h0, "halted");
   endtask
   // ==========
   // Tests, about 1000 cycles; watchdog at twenty times that
   initial begin
      #2000000;
      miscompares++;
      conclude();
   end
   initial begin
      repeat (2) @(posedge clk);
      #10;
      chk(rst_o === 1'h1 && en === 1'h0 && sclk === 1'h1 && oe === 1'h0, "reset");
      nrst = 1'h1;
      src_lo = 1'h1;
      wr(1'h1, 8'h00);
      wr(1'h0, 8'h04);
      chk(rst_o === 1'h1 && en === 1'h0, "write reset");
      repeat (2) @(posedge clk);
      #10;
      chk(en === 1'h1 && run === 1'h1 && rst_o === 1'h0, "enable");
      gap(4);
      wr(1'h0, 8'h05);
      gap(5);
      wr(1'h1, 8'h01);
      wr(1'h0, 8'h00);
      gap(256);
      wr(1'h1, 8'h00);
      byp = 1'h0;
      wr(1'h0, 8'h04);
      gap(64);
      for (int k = 0; k < 4; k++) begin
         wr(1'h1, 8'h00);
         {src_hi, src_lo} = k[1:0];
         wr(1'h0, 8'h04);
         repeat (4) @(posedge clk);
         #10;
         hi = 0;
         repeat (8) begin
            if (tx_out === 1'h1) hi++;
            @(posedge clk);
            #10;
         end
         chk(oe === (k != 0) && exp_mode === (k == 3) && sclk === (k < 2), "tx pin");
         chk(hi == ((k == 1) ? 4 : 0), "tx pin duty");
      end
      wr(1'h1, 8'h00);
      {src_hi, src_lo} = 2'h0;
      byp = 1'h1;
      wr(1'h0, 8'h04);
      repeat (2) @(posedge clk);
      for (int c = 0; c < 36; c++) begin
         @(posedge clk);
         #10;
         txp = (c < 32) && c[1];
         if (txt === 1'h1) ntx++;
      end
      chk(ntx == 8, "tx pin clock");
      wr(1'h1, 8'h00);
      {src_hi, src_lo} = 2'h1;
      byp = 1'h1;
      sync = 1'h1;
      rxen = 1'h1;
      wr(1'h0, 8'h01);
      frame(8'hA5, 8, 1'h1);
      frame(8'h3C, 8, 1'h1);
      rxen = 1'h0;
      frame(8'hFF, 0, 1'h1);
      rxen = 1'h1;
      pol = 1'h0;
      frame(8'h0F, 0, 1'h1);
      conclude();
   end
endmodule
`default_nettype wire
